/* dtc_defs.vh */
// Purpose: Constants for the dual timer/counter control register block.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes:   Field positions are bit numbers within an 8-bit register.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define DTC_IDX_TCTL   10'h088
`define DTC_IDX_TMODE  10'h089
`define DTC_IDX_TL0    10'h08a
`define DTC_IDX_TL1    10'h08b
`define DTC_IDX_TH0    10'h08c
`define DTC_IDX_TH1    10'h08d
`define DTC_IDX_PWMC   10'h091
`define DTC_IDX_RL0    10'h0f2
`define DTC_IDX_RL1    10'h0f3
`define DTC_IDX_RH0    10'h0f4
`define DTC_IDX_RH1    10'h0f5
`define DTC_IDX_ISTAT  10'h0a0
`define DTC_IDX_IMASK  10'h0a1
`define DTC_IDX_BITWR  10'h0a2

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define DTC_OVF1  7
`define DTC_RUN1  6
`define DTC_OVF0  5
`define DTC_RUN0  4
`define DTC_EXT1  3
`define DTC_TYP1  2
`define DTC_EXT0  1
`define DTC_TYP0  0

// Mode register nibble fields (channel one adds 4).
`define DTC_GATE  3
`define DTC_CSEL  2
`define DTC_M_HI  1
`define DTC_M_LO  0
`define DTC_CH1   4

// Interrupt status and mask bits.
`define DTC_IS_OVF0  0
`define DTC_IS_OVF1  1
`define DTC_IS_EXT0  2
`define DTC_IS_EXT1  3

// ----------------------------------------------------------------------
// Modes and reset values
// ----------------------------------------------------------------------
`define DTC_MODE_13   2'h0
`define DTC_MODE_16   2'h1
`define DTC_MODE_AR8  2'h2
`define DTC_MODE_SPL  2'h3
`define DTC_RST_TCTL  8'h00
`define DTC_RST_TMODE 8'h00
`define DTC_RST_PWMC  8'h24
`define DTC_RST_CNT   8'h00

`endif

/* dtc_timer.v */
// Purpose: Two 16-bit timer/counters with control, mode, count and
//          reload registers behind an APB slave.
// Assumes: Pins are asynchronous; acknowledge pulses come from pclk logic.
// Notes:   Timers with select clear count every pclk while enabled; no prescaler is applied.
//
// Contract
// - Overflow sets channel flag bit 7 or 5; vector acknowledge clears it.
// - Run bits 6 and 4 switch each channel; count only while set.
// - Edge flags bits 3 and 1 set on trigger, cleared when processed.
// - Type bits 2 and 0: one is falling edge, zero is low level.
// - Control register at 88H, resets zero, single bits writable.
// - Mode register at 089H, resets zero, whole byte access only.
// - Mode upper nibble channel one, lower nibble channel zero.
// - Gate set: count only while interrupt pin high and run set.
// - Select clear counts clock; select set counts count pin events.
// - Mode field zero is mode 0, the reset default.
// - Reload bytes at F2H to F5H are plain storage outside mode 1.
// - Count bytes: low at 8AH, 8BH; high at 8CH, 8DH.
// - Modes: 13-bit, 16-bit, 8-bit auto-reload and split timer.
// - Mode 1 cascades bytes to 16 bits, reloads from reload bytes.
// - Mode 2 counts low byte, reloads it from high byte.
// - Count on high sample then low sample; value shows next cycle.
`timescale 1ns/1ps
`include "dtc_defs.vh"

module dtc_timer #(
  parameter ADDR_W = 12
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  output reg  [31:0]       prdata,
  output reg               pready,
  output reg               pslverr,
  input  wire              ext_irq_pin_zero,
  input  wire              ext_irq_pin_one,
  input  wire              count_input_pin_zero,
  input  wire              count_input_pin_one,
  input  wire              ack_ovf_zero,
  input  wire              ack_ovf_one,
  input  wire              ack_ext_zero,
  input  wire              ack_ext_one,
  output reg               irq,
  output reg  [7:0]        tctl_flags
);

  // --------------------------------------------------------------------
  // Counting step
  // --------------------------------------------------------------------
  // One increment for a channel; returns {overflow, high, low}.
  function [16:0] dtc_step;
    input [1:0] mode;
    input [7:0] lo;
    input [7:0] hi;
    input [7:0] rlo;
    input [7:0] rhi;
    reg   [12:0] c13;
    reg   [16:0] r;
    begin
      c13 = {hi, lo[4:0]} + 13'h0001;
      r   = {1'b0, hi, lo};
      case (mode)
        `DTC_MODE_13: begin
          // 13-bit count: low five bits prescale the high byte.
          r = {({hi, lo[4:0]} == 13'h1fff), c13[12:5], lo[7:5], c13[4:0]};
        end
        `DTC_MODE_16: begin
          if ({hi, lo} == 16'hffff) begin
            r = {1'b1, rhi, rlo};
          end else begin
            r = {1'b0, ({hi, lo} + 16'h0001)};
          end
        end
        `DTC_MODE_AR8: begin
          if (lo == 8'hff) begin
            r = {1'b1, hi, hi};
          end else begin
            r = {1'b0, hi, (lo + 8'h01)};
          end
        end
        default: begin
          r = {(lo == 8'hff), hi, (lo + 8'h01)};
        end
      endcase
      dtc_step = r;
    end
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  reg  [7:0] tctl;
  reg  [7:0] tmode;
  reg  [7:0] tl0;
  reg  [7:0] tl1;
  reg  [7:0] th0;
  reg  [7:0] th1;
  reg  [7:0] pwmc;
  reg  [7:0] rl0;
  reg  [7:0] rl1;
  reg  [7:0] rh0;
  reg  [7:0] rh1;
  reg  [3:0] istat;
  reg  [3:0] imask;
  reg  [3:0] pin_s1;
  reg  [3:0] pin_s2;
  reg  [3:0] pin_s3;
  reg  [3:0] pin_lvl;
  reg  [3:0] pin_prev;

  reg  [7:0]  next_tctl;
  reg  [7:0]  next_tl0;
  reg  [7:0]  next_tl1;
  reg  [7:0]  next_th0;
  reg  [7:0]  next_th1;
  reg  [3:0]  next_istat;
  reg  [31:0] rd_data;
  reg         hit;
  reg         ov0;
  reg         ov1;
  reg         ovs;
  reg  [16:0] st0;
  reg  [16:0] st1;

  wire [9:0] idx = paddr[11:2];
  wire [3:0] pin_fall = pin_prev & ~pin_lvl;
  wire [1:0] mode0 = tmode[`DTC_M_HI:`DTC_M_LO];
  wire [1:0] mode1 = tmode[`DTC_CH1+`DTC_M_HI:`DTC_CH1+`DTC_M_LO];
  wire       wr = psel & penable & pready & pwrite & hit;
  wire       set_e0;
  wire       set_e1;
  wire       en0;
  wire       en1;
  wire       tick0;
  wire       tick1;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  // Three stages; the level moves only when stages two and three agree.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1   <= 4'hf;
      pin_s2   <= 4'hf;
      pin_s3   <= 4'hf;
      pin_lvl  <= 4'hf;
      pin_prev <= 4'hf;
    end else begin
      pin_s1   <= {count_input_pin_one, count_input_pin_zero,
                   ext_irq_pin_one, ext_irq_pin_zero};
      pin_s2   <= pin_s1;
      pin_s3   <= pin_s2;
      pin_lvl  <= (pin_s2 & pin_s3) | (pin_lvl & (pin_s2 ^ pin_s3));
      pin_prev <= pin_lvl;
    end
  end

  // --------------------------------------------------------------------
  // Channel enables and count sources
  // --------------------------------------------------------------------
  // Gate ties counting to the interrupt pin level as well as the run bit.
  assign en0 = tctl[`DTC_RUN0] & (~tmode[`DTC_GATE] | pin_lvl[0]);
  assign en1 = tctl[`DTC_RUN1] & (~tmode[`DTC_CH1+`DTC_GATE] | pin_lvl[1])
             & (mode1 != `DTC_MODE_SPL);
  // Counter function counts a high-then-low sample of the count pin.
  assign tick0 = tmode[`DTC_CSEL] ? pin_fall[2] : 1'b1;
  assign tick1 = tmode[`DTC_CH1+`DTC_CSEL] ? pin_fall[3] : 1'b1;
  // Falling edge or low level, chosen per input by its type bit.
  assign set_e0 = tctl[`DTC_TYP0] ? pin_fall[0] : ~pin_lvl[0];
  assign set_e1 = tctl[`DTC_TYP1] ? pin_fall[1] : ~pin_lvl[1];

  // --------------------------------------------------------------------
  // Address decode and read mux
  // --------------------------------------------------------------------
  // Unmapped or misaligned addresses answer with an error.
  always @* begin
    hit     = (paddr[1:0] == 2'b00);
    rd_data = 32'h00000000;
    case (idx)
      `DTC_IDX_TCTL:  rd_data[7:0] = tctl;
      `DTC_IDX_TMODE: rd_data[7:0] = tmode;
      `DTC_IDX_TL0:   rd_data[7:0] = tl0;
      `DTC_IDX_TL1:   rd_data[7:0] = tl1;
      `DTC_IDX_TH0:   rd_data[7:0] = th0;
      `DTC_IDX_TH1:   rd_data[7:0] = th1;
      `DTC_IDX_PWMC:  rd_data[7:0] = pwmc;
      `DTC_IDX_RL0:   rd_data[7:0] = rl0;
      `DTC_IDX_RL1:   rd_data[7:0] = rl1;
      `DTC_IDX_RH0:   rd_data[7:0] = rh0;
      `DTC_IDX_RH1:   rd_data[7:0] = rh1;
      `DTC_IDX_ISTAT: rd_data[3:0] = istat;
      `DTC_IDX_IMASK: rd_data[3:0] = imask;
      `DTC_IDX_BITWR: rd_data[7:0] = 8'h00;
      default:        hit = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------
  // Hardware steps first; a software write to the same byte wins.
  always @* begin
    next_tl0 = tl0;
    next_th0 = th0;
    next_tl1 = tl1;
    next_th1 = th1;
    ov0 = 1'b0;
    ov1 = 1'b0;
    ovs = 1'b0;
    st0 = dtc_step(mode0, tl0, th0, rl0, rh0);
    st1 = dtc_step(mode1, tl1, th1, rl1, rh1);
    if (en0 & tick0) begin
      ov0      = st0[16];
      next_tl0 = st0[7:0];
      if (mode0 != `DTC_MODE_SPL) begin
        next_th0 = st0[15:8];
      end
    end
    // Split mode: high byte of channel zero runs on channel one's run bit.
    if ((mode0 == `DTC_MODE_SPL) && tctl[`DTC_RUN1]) begin
      ovs      = (th0 == 8'hff);
      next_th0 = th0 + 8'h01;
    end
    if (en1 & tick1) begin
      ov1      = st1[16];
      next_tl1 = st1[7:0];
      next_th1 = st1[15:8];
    end
    if (wr && (idx == `DTC_IDX_TL0)) next_tl0 = pwdata[7:0];
    if (wr && (idx == `DTC_IDX_TH0)) next_th0 = pwdata[7:0];
    if (wr && (idx == `DTC_IDX_TL1)) next_tl1 = pwdata[7:0];
    if (wr && (idx == `DTC_IDX_TH1)) next_th1 = pwdata[7:0];
  end

  // --------------------------------------------------------------------
  // Control flags and interrupt status
  // --------------------------------------------------------------------
  // Acknowledge clears, hardware sets win over it, software write wins last.
  always @* begin
    next_tctl = tctl;
    if (ack_ovf_zero) next_tctl[`DTC_OVF0] = 1'b0;
    if (ack_ovf_one)  next_tctl[`DTC_OVF1] = 1'b0;
    if (ack_ext_zero) next_tctl[`DTC_EXT0] = 1'b0;
    if (ack_ext_one)  next_tctl[`DTC_EXT1] = 1'b0;
    if (ov0)          next_tctl[`DTC_OVF0] = 1'b1;
    if (ov1 | ovs)    next_tctl[`DTC_OVF1] = 1'b1;
    if (set_e0)       next_tctl[`DTC_EXT0] = 1'b1;
    if (set_e1)       next_tctl[`DTC_EXT1] = 1'b1;
    if (wr && (idx == `DTC_IDX_TCTL)) begin
      next_tctl = pwdata[7:0];
    end
    if (wr && (idx == `DTC_IDX_BITWR)) begin
      next_tctl[pwdata[2:0]] = pwdata[3];
    end
    // Events are sticky; a set in the clearing cycle is kept.
    next_istat = istat;
    if (wr && (idx == `DTC_IDX_ISTAT)) next_istat = istat & ~pwdata[3:0];
    next_istat[`DTC_IS_OVF0] = next_istat[`DTC_IS_OVF0] | ov0;
    next_istat[`DTC_IS_OVF1] = next_istat[`DTC_IS_OVF1] | ov1 | ovs;
    next_istat[`DTC_IS_EXT0] = next_istat[`DTC_IS_EXT0]
                               | (set_e0 & ~tctl[`DTC_EXT0]);
    next_istat[`DTC_IS_EXT1] = next_istat[`DTC_IS_EXT1]
                               | (set_e1 & ~tctl[`DTC_EXT1]);
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  // Whole-byte registers take a write only at the access edge.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tctl  <= `DTC_RST_TCTL;
      tmode <= `DTC_RST_TMODE;
      tl0   <= `DTC_RST_CNT;
      tl1   <= `DTC_RST_CNT;
      th0   <= `DTC_RST_CNT;
      th1   <= `DTC_RST_CNT;
      pwmc  <= `DTC_RST_PWMC;
      rl0   <= `DTC_RST_CNT;
      rl1   <= `DTC_RST_CNT;
      rh0   <= `DTC_RST_CNT;
      rh1   <= `DTC_RST_CNT;
      istat <= 4'h0;
      imask <= 4'h0;
    end else begin
      tctl  <= next_tctl;
      tl0   <= next_tl0;
      th0   <= next_th0;
      tl1   <= next_tl1;
      th1   <= next_th1;
      istat <= next_istat;
      if (wr) begin
        case (idx)
          `DTC_IDX_TMODE: tmode <= pwdata[7:0];
          `DTC_IDX_PWMC:  pwmc  <= pwdata[7:0];
          `DTC_IDX_RL0:   rl0   <= pwdata[7:0];
          `DTC_IDX_RL1:   rl1   <= pwdata[7:0];
          `DTC_IDX_RH0:   rh0   <= pwdata[7:0];
          `DTC_IDX_RH1:   rh1   <= pwdata[7:0];
          `DTC_IDX_IMASK: imask <= pwdata[3:0];
          default:        imask <= imask;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // APB answer and outputs
  // --------------------------------------------------------------------
  // No wait state: ready, data and error are loaded in the setup cycle.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= 32'h00000000;
      irq        <= 1'b0;
      tctl_flags <= `DTC_RST_TCTL;
    end else begin
      pready     <= psel & ~penable;
      pslverr    <= psel & ~penable & ~hit;
      prdata     <= (psel & ~penable & ~pwrite) ? rd_data : 32'h00000000;
      irq        <= |(next_istat & imask);
      tctl_flags <= next_tctl;
    end
  end

endmodule // dtc_timer

/* dtc_core_model.sv */
// Purpose: Core side model that vectors to pending timer flags.
// Assumes: Acknowledges are one-cycle pulses in the pclk domain.
// Notes:   Vectoring is enabled by the bench with vec_en.
`timescale 1ns/1ps
module dtc_core_model (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       vec_en,
  input  wire [7:0] tctl_flags,
  output reg        ack_ovf_zero,
  output reg        ack_ovf_one,
  output reg        ack_ext_zero,
  output reg        ack_ext_one
);
  // Pulse an acknowledge for each pending flag; never twice in a row.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_ovf_zero <= 1'b0;
      ack_ovf_one  <= 1'b0;
      ack_ext_zero <= 1'b0;
      ack_ext_one  <= 1'b0;
    end else begin
      ack_ovf_zero <= vec_en && tctl_flags[5] && !ack_ovf_zero;
      ack_ovf_one  <= vec_en && tctl_flags[7] && !ack_ovf_one;
      ack_ext_zero <= vec_en && tctl_flags[1] && !ack_ext_zero;
      ack_ext_one  <= vec_en && tctl_flags[3] && !ack_ext_one;
    end
  end
endmodule // dtc_core_model

/* dtc_timer_properties.sv */
// Purpose: Port assertions for the dual timer control block.
// Assumes: One clock domain, reset active low.
// Notes:   Control flags are watched through tctl_flags.
`timescale 1ns/1ps
module dtc_timer_props #(
  parameter ADDR_W = 12
) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0]       pwdata,
  input wire              pready,
  input wire              pslverr,
  input wire              ext_irq_pin_zero,
  input wire              ext_irq_pin_one,
  input wire              ack_ovf_zero,
  input wire              ack_ext_one,
  input wire [7:0]        tctl_flags
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc  = psel && penable && pready && pwrite;
  wire idle = !(psel && penable);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  // The slave answers in the first access cycle, with no wait cycle, for one cycle.
  property p_ready;
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("late ready");
  property p_refuse;
    psel && !penable && paddr[1:0] != 2'b00 |=> pslverr && pready;
  endproperty
  a_refuse: assert property (p_refuse) else $error("no error");
  property p_ctl_wr;
    acc && paddr == 'h220 |=> tctl_flags == $past(pwdata[7:0]);
  endproperty
  a_ctl_wr: assert property (p_ctl_wr) else $error("ctl write");
  property p_bit_wr;
    acc && paddr == 'h288 |=>
      tctl_flags[$past(pwdata[2:0])] == $past(pwdata[3]);
  endproperty
  a_bit_wr: assert property (p_bit_wr) else $error("bit write");
  property p_ovf_ack;
    ack_ovf_zero && idle && !tctl_flags[4] && !tctl_flags[6]
      |=> !tctl_flags[5];
  endproperty
  a_ovf_ack: assert property (p_ovf_ack) else $error("ack");
  property p_stopped;
    !tctl_flags[4] && !tctl_flags[6] && idle |=> !$rose(tctl_flags[5]);
  endproperty
  a_stopped: assert property (p_stopped) else $error("ran");
  property p_edge;
    tctl_flags[0] && $fell(ext_irq_pin_zero) |-> ##[1:8] tctl_flags[1];
  endproperty
  a_edge: assert property (p_edge) else $error("edge missed");
  property p_level;
    (!ext_irq_pin_one && !tctl_flags[2] && !ack_ext_one && idle)[*6]
      |=> tctl_flags[3];
  endproperty
  a_level: assert property (p_level) else $error("level");
endmodule // dtc_timer_props

bind dtc_timer dtc_timer_props #(.ADDR_W(ADDR_W)) props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .ext_irq_pin_zero(ext_irq_pin_zero),
  .ext_irq_pin_one(ext_irq_pin_one), .ack_ovf_zero(ack_ovf_zero),
  .ack_ext_one(ack_ext_one), .tctl_flags(tctl_flags));

/* tb.sv */
// Purpose: Register level test of the dual timer block over APB.
// Assumes: Zero wait APB slave; control bit writes at 0x288.
// Notes:   Count values are read after the channel is stopped, or while it is gated off.
`timescale 1ns/1ps
module tb;
  reg         pclk, presetn, psel, penable, pwrite, vec_en;
  reg         re, pin_e0, pin_e1, pin_c0, pin_c1;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rv;
  wire [31:0] prdata;
  wire        pready, pslverr, irq, a_oz, a_oo, a_ez, a_eo;
  wire [7:0]  tctl_flags;
  integer     err_count, n_checks, i;

  dtc_timer #(.ADDR_W(12)) dtc_timer_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_irq_pin_zero(pin_e0),
    .ext_irq_pin_one(pin_e1), .count_input_pin_zero(pin_c0),
    .count_input_pin_one(pin_c1), .ack_ovf_zero(a_oz),
    .ack_ovf_one(a_oo), .ack_ext_zero(a_ez), .ack_ext_one(a_eo),
    .irq(irq), .tctl_flags(tctl_flags));
  dtc_core_model dtc_core_model_i (.pclk(pclk), .presetn(presetn),
    .vec_en(vec_en), .tctl_flags(tctl_flags), .ack_ovf_zero(a_oz),
    .ack_ovf_one(a_oo), .ack_ext_zero(a_ez), .ack_ext_one(a_eo));

  // Free running bus clock.
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task report_and_stop;
    begin
      if (err_count == 0 && n_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge pclk);
  endtask
  // One APB transfer; read data and error are taken at the ready edge.
  task apb(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      @(posedge pclk);
      while (pready !== 1'b1) begin
        n = n + 1;
        if (n > 20) begin
          err_count = err_count + 1;
          report_and_stop;
        end
        @(posedge pclk);
      end
      rv = prdata;
      re = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rdc(input [11:0] a, input [31:0] e);
    begin
      apb(a, 1'b0, 32'h0);
      chk(rv, e);
    end
  endtask
  task bw(input [3:0] c);
    apb(12'h288, 1'b1, {28'h0, c});
  endtask
  task wait_irq;
    integer n;
    begin
      n = 0;
      while (irq !== 1'b1 && n < 50) begin
        @(posedge pclk);
        n = n + 1;
      end
      if (n == 50) begin
        err_count = err_count + 1;
        report_and_stop;
      end
    end
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, vec_en, presetn} = 5'h0;
    {pin_e0, pin_e1, pin_c0, pin_c1} = 4'hf;
    paddr = 12'h0;
    pwdata = 32'h0;
    err_count = 0;
    n_checks = 0;
    cyc(10);
    presetn <= 1'b1;
    rdc(12'h220, 32'h0);
    rdc(12'h224, 32'h0);
    rdc(12'h244, 32'h24);
    rdc(12'h280, 32'h0);
    wr(12'h220, 32'h05);
    rdc(12'h220, 32'h05);
    wr(12'h220, 32'h0);
    wr(12'h224, 32'hffffff0d);
    rdc(12'h224, 32'h0d);
    // All stores first, then all reads, so aliasing shows up.
    for (i = 0; i < 8; i = i + 1)
      wr(12'(i < 4 ? 'h228 + 4 * i : 'h3b8 + 4 * i), 32'hffffff30 + i);
    for (i = 0; i < 8; i = i + 1)
      rdc(12'(i < 4 ? 'h228 + 4 * i : 'h3b8 + 4 * i), 32'h30 + i);
    // The error flag rides in bit 31 so one compare covers flag and data.
    apb(12'h3fc, 1'b0, 32'h0);
    chk({re, rv[30:0]}, 32'h80000000);
    apb(12'h222, 1'b0, 32'h0);
    chk({re, rv[30:0]}, 32'h80000000);
    wr(12'h224, 32'h01);
    wr(12'h228, 32'hfe);
    wr(12'h230, 32'hff);
    wr(12'h3c8, 32'h34);
    wr(12'h3d0, 32'h12);
    wr(12'h284, 32'h1);
    bw(4'hc);
    wait_irq;
    chk(32'(tctl_flags[5]), 32'h1);
    bw(4'h4);
    rdc(12'h230, 32'h12);
    rdc(12'h280, 32'h1);
    wr(12'h284, 32'h0);
    cyc(2);
    chk(32'(irq), 32'h0);
    wr(12'h284, 32'h1);
    wr(12'h280, 32'h1);
    cyc(2);
    chk(32'(irq), 32'h0);
    // Counter function on channel zero, five falling edges.
    wr(12'h224, 32'h04);
    wr(12'h228, 32'h0);
    bw(4'hc);
    for (i = 0; i < 5; i = i + 1) begin
      pin_c0 <= 1'b0;
      cyc(4);
      pin_c0 <= 1'b1;
      cyc(4);
    end
    cyc(8);
    bw(4'h4);
    rdc(12'h228, 32'h05);
    // Gated channel one; counter select one stays clear.
    pin_e1 <= 1'b0;
    wr(12'h224, 32'h90);
    wr(12'h22c, 32'h0);
    bw(4'he);
    cyc(20);
    rdc(12'h22c, 32'h0);
    chk(32'(tctl_flags[3]), 32'h1);
    pin_e1 <= 1'b1;
    cyc(20);
    bw(4'h6);
    apb(12'h22c, 1'b0, 32'h0);
    chk(32'(rv != 0), 32'h1);
    wr(12'h224, 32'h20);
    wr(12'h22c, 32'hfe);
    wr(12'h234, 32'hf0);
    bw(4'he);
    cyc(30);
    bw(4'h6);
    rdc(12'h234, 32'hf0);
    apb(12'h22c, 1'b0, 32'h0);
    chk(32'(rv[7:4]), 32'hf);
    chk(32'(tctl_flags[7]), 32'h1);
    bw(4'h8);
    pin_e0 <= 1'b0;
    cyc(6);
    pin_e0 <= 1'b1;
    cyc(8);
    chk(32'(tctl_flags[1]), 32'h1);
    vec_en <= 1'b1;
    cyc(6);
    chk(32'(tctl_flags & 8'haa), 32'h0);
    report_and_stop;
  end
endmodule // tb
